// ==== ccp_regs.svh ====
// register indices, field positions and reset values of the capture/compare/pwm unit
// assumes a 32-bit word bus; byte address is four times the index
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH

`define IDX_VALUE 10'h340
`define IDX_CTRL 10'h342
`define IDX_TRIG 10'h343
`define IDX_TSEL 10'h34c

`define CTRL_EN_BIT 7
`define CTRL_OUT_BIT 5
`define CTRL_FMT_BIT 4
`define CTRL_MODE_MSB 3

`define CTRL_RESET 8'h00
`define TRIG_RESET 3'h0
`define TSEL_RESET 8'h15
`define TSEL_FIELD_MSB 1
`define TSEL_SECOND 2'h2

`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hf

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== ccp_pkg.sv ====
// types shared by the capture/compare/pwm unit and its bench
// assumes ccp_regs.svh supplies the numeric constants
package ccp_pkg;

    typedef enum logic [3:0]
    {
        MODE_OFF = 4'h0,
        MODE_TOG_CLR = 4'h1,
        MODE_TOG = 4'h2,
        MODE_CAP_ANY = 4'h3,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_4 = 4'h6,
        MODE_CAP_16 = 4'h7,
        MODE_SET = 4'h8,
        MODE_CLR = 4'h9,
        MODE_PULSE = 4'ha,
        MODE_PULSE_CLR = 4'hb
    } mode_type;

    // time bases offered by the timers; index a is the first of each pair
    typedef struct packed {
        logic [15:0] count_a;
        logic [15:0] count_b;
        logic [9:0] base_a;
        logic [9:0] base_b;
        logic period_a;
        logic period_b;
    } timers_type;

endpackage

// ==== capture_compare_pwm_unit.sv ====
// capture/compare/pwm unit with an axi4-lite register slave
// assumes timers, trigger sources and bus are synchronous to REF_CLK_I
`timescale 1ns/1ps
`include "ccp_regs.svh"

module capture_compare_pwm_unit #(
    parameter int TRIG_W = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [31:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    input wire logic [TRIG_W-1:0] TRIGGER_I,
    input wire ccp_pkg::timers_type TIMERS_I,
    output logic UNIT_PIN_O,
    output logic UNIT_EVENT_FLAG_O,
    output logic [1:0] TIMER_CLEAR_O
);

    logic en;
    logic fmt;
    logic [3:0] mode;
    logic [2:0] trig_sel;
    logic [7:0] tsel;
    logic [15:0] value;
    logic [9:0] duty_buf;
    logic out_level;
    logic trig_prev;
    logic match_prev;
    logic [3:0] edge_count;
    logic aw_full;
    logic w_full;
    logic [31:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic active;
    logic use_second;
    logic [15:0] count;
    logic [9:0] base;
    logic period;
    logic trig;
    logic rise;
    logic fall;
    logic capture;
    logic match;
    logic hit;
    logic [9:0] duty;
    logic next_out;
    logic pulse_on;

    function automatic logic is_pwm(input logic [3:0] m);
        return m[3] && m[2];
    endfunction

    function automatic logic is_capture(input logic [3:0] m);
        return m >= ccp_pkg::MODE_CAP_ANY && m <= ccp_pkg::MODE_CAP_16;
    endfunction

    function automatic logic idx_hit(input logic [31:0] a, input logic [9:0] idx);
        return a[31:12] == 20'h00000 && a[11:2] == idx;
    endfunction

    function automatic logic known(input logic [31:0] a);
        return idx_hit(a, `IDX_VALUE) || idx_hit(a, `IDX_CTRL)
            || idx_hit(a, `IDX_TRIG) || idx_hit(a, `IDX_TSEL);
    endfunction

    // mode 0000 disables even with the enable bit set
    assign active = en && mode != ccp_pkg::MODE_OFF;

    // reserved codes 00 and 11 fall back to the first pair
    assign use_second = tsel[`TSEL_FIELD_MSB:0] == `TSEL_SECOND;
    assign count = use_second ? TIMERS_I.count_b : TIMERS_I.count_a;
    assign base = use_second ? TIMERS_I.base_b : TIMERS_I.base_a;
    assign period = use_second ? TIMERS_I.period_b : TIMERS_I.period_a;

    assign trig = TRIGGER_I[trig_sel];
    assign rise = trig && !trig_prev;
    assign fall = !trig && trig_prev;

    always_comb
    begin
        capture = 1'b0;
        if (active)
        begin
            case (mode)
                ccp_pkg::MODE_CAP_ANY: capture = rise || fall;
                ccp_pkg::MODE_CAP_FALL: capture = fall;
                ccp_pkg::MODE_CAP_RISE: capture = rise;
                // counter runs to fifteen; its low two bits mark every fourth rise
                ccp_pkg::MODE_CAP_4:
                    capture = rise && (edge_count & `PRESCALE_4) == `PRESCALE_4;
                ccp_pkg::MODE_CAP_16: capture = rise && edge_count == `PRESCALE_16;
                default: capture = 1'b0;
            endcase
        end
    end

    // edge detection on the timer equality avoids repeat actions
    // while a prescaled timer dwells on the matching count
    assign match = count == value;
    assign hit = active && !is_pwm(mode) && !is_capture(mode) && match && !match_prev;

    // right aligned uses bits 9:0, left aligned bits 15:6
    assign duty = fmt ? value[15:6] : value[9:0];

    always_comb
    begin
        next_out = out_level;
        pulse_on = 1'b0;
        if (!active)
        begin
            next_out = 1'b0;
        end
        else if (is_pwm(mode))
        begin
            if (period)
            begin
                next_out = duty != 10'h000;
            end
            else if (base == duty_buf)
            begin
                next_out = 1'b0;
            end
        end
        else if (hit)
        begin
            case (mode)
                ccp_pkg::MODE_SET: next_out = 1'b1;
                ccp_pkg::MODE_CLR: next_out = 1'b0;
                ccp_pkg::MODE_PULSE, ccp_pkg::MODE_PULSE_CLR:
                begin
                    next_out = 1'b1;
                    pulse_on = 1'b1;
                end
                ccp_pkg::MODE_TOG, ccp_pkg::MODE_TOG_CLR: next_out = !out_level;
                default: next_out = out_level;
            endcase
        end
        else if (mode == ccp_pkg::MODE_PULSE || mode == ccp_pkg::MODE_PULSE_CLR)
        begin
            next_out = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            out_level <= 1'b0;
            UNIT_PIN_O <= 1'b0;
        end
        else
        begin
            out_level <= next_out;
            UNIT_PIN_O <= next_out;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            trig_prev <= 1'b0;
            match_prev <= 1'b0;
        end
        else
        begin
            trig_prev <= trig;
            match_prev <= match;
        end
    end

    // prescaler restarts whenever control is written or the unit idles
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            edge_count <= 4'h0;
        end
        else if (!active || (do_write && idx_hit(aw_addr, `IDX_CTRL)))
        begin
            edge_count <= 4'h0;
        end
        else if (rise)
        begin
            edge_count <= edge_count + 4'h1;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            duty_buf <= 10'h000;
        end
        else if (active && is_pwm(mode) && period)
        begin
            duty_buf <= duty;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            UNIT_EVENT_FLAG_O <= 1'b0;
            TIMER_CLEAR_O <= 2'h0;
        end
        else
        begin
            UNIT_EVENT_FLAG_O <= capture || hit || (active && is_pwm(mode) && period);
            TIMER_CLEAR_O <= 2'h0;
            if (hit && (mode == ccp_pkg::MODE_PULSE_CLR || mode == ccp_pkg::MODE_TOG_CLR))
            begin
                TIMER_CLEAR_O <= use_second ? 2'h2 : 2'h1;
            end
        end
    end

    // value is data, not control: no reset, so other resets keep it
    always_ff @(posedge REF_CLK_I)
    begin
        if (capture)
        begin
            value <= count;
        end
        else if (do_write && idx_hit(aw_addr, `IDX_VALUE))
        begin
            if (wstrb[0])
            begin
                value[7:0] <= wdata[7:0];
            end
            if (wstrb[1])
            begin
                value[15:8] <= wdata[15:8];
            end
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            en <= 1'(`CTRL_RESET >> `CTRL_EN_BIT);
            fmt <= 1'b0;
            mode <= 4'h0;
            trig_sel <= `TRIG_RESET;
            tsel <= `TSEL_RESET;
        end
        else if (do_write && wstrb[0])
        begin
            if (idx_hit(aw_addr, `IDX_CTRL))
            begin
                en <= wdata[`CTRL_EN_BIT];
                fmt <= wdata[`CTRL_FMT_BIT];
                mode <= wdata[`CTRL_MODE_MSB:0];
            end
            else if (idx_hit(aw_addr, `IDX_TRIG))
            begin
                trig_sel <= wdata[2:0];
            end
            else if (idx_hit(aw_addr, `IDX_TSEL))
            begin
                tsel <= wdata[7:0];
            end
        end
    end

    // write channel: address and data taken in either order
    assign do_write = aw_full && w_full && !BVALID_O;
    assign wr_hit = known(aw_addr);

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            aw_full <= 1'b0;
            AWREADY_O <= 1'b0;
            aw_addr <= 32'h00000000;
        end
        else if (AWVALID_I && AWREADY_O)
        begin
            aw_full <= 1'b1;
            AWREADY_O <= 1'b0;
            aw_addr <= AWADDR_I;
        end
        else if (do_write)
        begin
            aw_full <= 1'b0;
        end
        else if (!aw_full && !BVALID_O)
        begin
            AWREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            w_full <= 1'b0;
            WREADY_O <= 1'b0;
            wdata <= 32'h00000000;
            wstrb <= 4'h0;
        end
        else if (WVALID_I && WREADY_O)
        begin
            w_full <= 1'b1;
            WREADY_O <= 1'b0;
            wdata <= WDATA_I;
            wstrb <= WSTRB_I;
        end
        else if (do_write)
        begin
            w_full <= 1'b0;
        end
        else if (!w_full && !BVALID_O)
        begin
            WREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            BVALID_O <= 1'b0;
            BRESP_O <= `RESP_OKAY;
        end
        else if (do_write)
        begin
            BVALID_O <= 1'b1;
            BRESP_O <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (BREADY_I)
        begin
            BVALID_O <= 1'b0;
        end
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit = known(ARADDR_I);
        if (idx_hit(ARADDR_I, `IDX_VALUE))
        begin
            rd_word[15:0] = value;
        end
        else if (idx_hit(ARADDR_I, `IDX_CTRL))
        begin
            rd_word[`CTRL_EN_BIT] = en;
            rd_word[`CTRL_OUT_BIT] = out_level;
            rd_word[`CTRL_FMT_BIT] = fmt;
            rd_word[`CTRL_MODE_MSB:0] = mode;
        end
        else if (idx_hit(ARADDR_I, `IDX_TRIG))
        begin
            rd_word[2:0] = trig_sel;
        end
        else if (idx_hit(ARADDR_I, `IDX_TSEL))
        begin
            rd_word[7:0] = tsel;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= `RESP_OKAY;
        end
        else if (ARVALID_I && ARREADY_O)
        begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b1;
            RDATA_O <= rd_word;
            RRESP_O <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (RVALID_O && RREADY_I)
        begin
            RVALID_O <= 1'b0;
        end
        else if (!RVALID_O)
        begin
            ARREADY_O <= 1'b1;
        end
    end

endmodule

// ==== timer_model.sv ====
// stand-in for the selected timers feeding the capture/compare/pwm unit
// assumes the unit's clock; counts hold while run_i is low unless clr_i clears them; base and the period pulse never stop
`timescale 1ns/1ps
module timer_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] clr_i,
    input wire logic [7:0] period_i,
    output ccp_pkg::timers_type tm_o
);
    logic [15:0] ca, cb;
    logic [9:0] base;
    logic per;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ca <= 16'h0000;
            cb <= 16'h8000;
            base <= 10'h000;
            per <= 1'b0;
        end
        else
        begin
            ca <= clr_i[0] ? 16'h0000 : ca + {15'h0000, run_i};
            cb <= clr_i[1] ? 16'h0000 : cb + {15'h0000, run_i};
            // pulse rides with the wrap, so it marks the increment after equality
            base <= (base == {period_i, 2'h3}) ? 10'h000 : base + 10'h001;
            per <= (base == {period_i, 2'h3});
        end
    end
    assign tm_o = '{count_a: ca, count_b: cb, base_a: base, base_b: base,
        period_a: per, period_b: per};
endmodule

// ==== capture_compare_pwm_unit_properties.sv ====
// port assertions for the capture/compare/pwm unit
// assumes one clock domain, bound to the unit's ports
`timescale 1ns/1ps
`include "ccp_regs.svh"
module capture_compare_pwm_unit_properties (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic [31:0] AWADDR_I,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic [31:0] ARADDR_I,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0] RRESP_O,
    input wire logic UNIT_EVENT_FLAG_O,
    input wire logic [1:0] TIMER_CLEAR_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    function automatic logic known(input logic [31:0] a);
        return a[1:0] == 2'h0 && a[31:12] == 20'h0 && (a[11:2] == `IDX_VALUE
            || a[11:2] == `IDX_CTRL || a[11:2] == `IDX_TRIG || a[11:2] == `IDX_TSEL);
    endfunction
    sequence s_wr_take;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    endsequence
    sequence s_rd_take;
        ARVALID_I && ARREADY_O;
    endsequence
    a_wr_answer: assert property (s_wr_take |=> !BVALID_O ##1 BVALID_O)
        else $error("write answer off time");
    a_wr_resp: assert property (s_wr_take |-> ##2 BRESP_O ==
        (known($past(AWADDR_I, 2)) ? `RESP_OKAY : `RESP_SLVERR))
        else $error("write response code wrong");
    a_rd_resp: assert property (s_rd_take |=> RVALID_O &&
        RRESP_O == (known($past(ARADDR_I)) ? `RESP_OKAY : `RESP_SLVERR))
        else $error("read answer wrong");
    a_rd_zero: assert property (s_rd_take and !known(ARADDR_I) |=> RDATA_O == 32'h0)
        else $error("unmapped read data not zero");
    a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write response dropped");
    a_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
        else $error("read data dropped");
    a_wr_block: assert property (s_wr_take |=> (!AWREADY_O && !WREADY_O)[*2])
        else $error("write readies back too soon");
    a_rd_block: assert property (s_rd_take |=> !ARREADY_O)
        else $error("read ready back too soon");
    a_clear_flag: assert property (TIMER_CLEAR_O != 2'h0 |-> UNIT_EVENT_FLAG_O
        && $onehot(TIMER_CLEAR_O))
        else $error("timer clear without flag");
    a_clear_pulse: assert property (TIMER_CLEAR_O != 2'h0 |=> TIMER_CLEAR_O == 2'h0)
        else $error("timer clear longer than a cycle");
endmodule
bind capture_compare_pwm_unit capture_compare_pwm_unit_properties u_props (.REF_CLK_I,
    .RST_I, .AWVALID_I, .AWREADY_O, .AWADDR_I, .WVALID_I, .WREADY_O, .BVALID_O, .BREADY_I,
    .BRESP_O, .ARVALID_I, .ARREADY_O, .ARADDR_I, .RVALID_O, .RREADY_I, .RDATA_O, .RRESP_O,
    .UNIT_EVENT_FLAG_O, .TIMER_CLEAR_O);

// ==== capture_compare_pwm_unit_tb.sv ====
// self-checking bench for the capture/compare/pwm unit
// assumes timer_model as the timers; the bench drives trigger lines
`timescale 1ns/1ps
`include "ccp_regs.svh"
module capture_compare_pwm_unit_tb;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
    logic rre = 1'b0, run = 1'b0, awr, wr, bv, arr, rv, pin, flg;
    logic [31:0] awa = '0, wd = '0, ara = '0, rd, v;
    logic [7:0] trg = 8'h00, per = 8'h03;
    logic [1:0] br, rr, clr;
    logic [2:0] s;
    logic [65:0] x, eq[$];
    ccp_pkg::timers_type tm;
    int num_errors = 0, checks_done = 0, seed = 96785, nflg = 0, i, k, n;
    always #5 clk = ~clk;
    capture_compare_pwm_unit u_capture_compare_pwm_unit (.REF_CLK_I(clk), .RST_I(rst),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wr),
        .WDATA_I(wd), .WSTRB_I(4'hf), .BVALID_O(bv), .BREADY_I(bre), .BRESP_O(br),
        .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rre),
        .RDATA_O(rd), .RRESP_O(rr), .TRIGGER_I(trg), .TIMERS_I(tm), .UNIT_PIN_O(pin),
        .UNIT_EVENT_FLAG_O(flg), .TIMER_CLEAR_O(clr));
    timer_model u_timer_model (.clk_i(clk), .rst_i(rst), .run_i(run), .clr_i(clr),
        .period_i(per), .tm_o(tm));
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic fail(input string m);
        num_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
            fail($sformatf("got %h want %h", g, e));
    endtask
    task automatic tmo();
        if (k >= 300)
        begin
            fail("wait ran out");
            end_of_test();
        end
    endtask
    // bready starts random to exercise a held response
    task automatic wr_reg(input logic [9:0] idx, input logic [15:0] d);
        @(posedge clk);
        awa <= {20'h0, idx, 2'h0};
        wd <= {16'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'($random(seed));
        @(posedge clk);
        for (k = 0; k < 300 && (awv || wv); k++)
        begin
            if (awr)
                awv <= 1'b0;
            if (wr)
                wv <= 1'b0;
            @(posedge clk);
        end
        for (; k < 300 && !(bv && bre); k++)
        begin
            bre <= 1'b1;
            @(posedge clk);
        end
        bre <= 1'b0;
        tmo();
    endtask
    task automatic rd_reg(input logic [9:0] idx, input logic [31:0] e, input logic [31:0] m,
        input logic [1:0] r);
        @(posedge clk);
        ara <= {20'h0, idx, 2'h0};
        arv <= 1'b1;
        rre <= 1'($random(seed));
        eq.push_back({r, m, e});
        @(posedge clk);
        for (k = 0; k < 300 && !arr; k++)
            @(posedge clk);
        arv <= 1'b0;
        for (; k < 300 && !(rv && rre); k++)
        begin
            rre <= 1'b1;
            @(posedge clk);
        end
        rre <= 1'b0;
        tmo();
    endtask
    always @(posedge clk)
    begin
        if (flg)
            nflg <= nflg + 1;
        if (rv && rre)
        begin
            x = eq.pop_front();
            chk(32'(rr), 32'(x[65:64]));
            chk(rd & x[63:32], x[31:0]);
        end
    end
    task automatic wt_flag();
        for (k = 0; k < 300 && !flg; k++)
            @(posedge clk);
        tmo();
    endtask
    task automatic pul(input logic [2:0] b, input int c);
        repeat (c)
        begin
            @(posedge clk);
            trg[b] <= 1'b1;
            repeat (2) @(posedge clk);
            trg[b] <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic cmp(input logic [3:0] m, input logic b, input logic [2:0] e);
        wr_reg(`IDX_VALUE, (b ? tm.count_b : tm.count_a) + 16'h0040);
        wr_reg(`IDX_CTRL, {12'h008, m});
        wt_flag();
        chk(32'({pin, clr}), 32'(e));
    endtask
    task automatic pwm(input logic e, input logic f, input logic [15:0] d, input int w);
        int j, c;
        c = 0;
        wr_reg(`IDX_VALUE, d);
        wr_reg(`IDX_CTRL, {8'h00, e, 2'h0, f, 4'hc});
        // skip a reload that may still carry the old alignment
        if (e)
        begin
            wt_flag();
            @(posedge clk);
            wt_flag();
        end
        @(posedge clk);
        for (j = 0; j < 4 * (int'(per) + 1); j++)
        begin
            if (pin === 1'b1)
                c++;
            @(posedge clk);
        end
        chk(c, w);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        v = $random(seed);
        wr_reg(10'h3ff, 16'h00ff);
        rd_reg(10'h3ff, 32'h0, 32'hffffffff, `RESP_SLVERR);
        rd_reg(`IDX_CTRL, 32'(`CTRL_RESET), 32'h9f, `RESP_OKAY);
        rd_reg(`IDX_TRIG, 32'(`TRIG_RESET), 32'h7, `RESP_OKAY);
        rd_reg(`IDX_TSEL, 32'(`TSEL_RESET), 32'hff, `RESP_OKAY);
        wr_reg(`IDX_VALUE, v[15:0]);
        rd_reg(`IDX_VALUE, {16'h0, v[15:0]}, 32'hffff, `RESP_OKAY);
        wr_reg(`IDX_CTRL, 16'h0023);
        rd_reg(`IDX_CTRL, 32'h3, 32'hbf, `RESP_OKAY);
        $display("registers done");
        run <= 1'b0;
        for (i = 0; i < 12; i++)
        begin
            s = (i < 5) ? 3'h0 : 3'(i - 4);
            wr_reg(`IDX_TRIG, {13'h0, s});
            wr_reg(`IDX_CTRL, {12'h008, (i < 5) ? 4'(i + 3) : 4'h5});
            n = nflg;
            if (i > 4)
                pul(s ^ 3'h1, 1);
            pul(s, (i == 3) ? 8 : (i == 4) ? 16 : 1);
            chk(nflg - n, (i == 0 || i == 3) ? 2 : 1);
        end
        rd_reg(`IDX_VALUE, {16'h0, tm.count_a}, 32'hffff, `RESP_OKAY);
        wr_reg(`IDX_TSEL, 16'h0016);
        pul(3'h7, 1);
        rd_reg(`IDX_VALUE, {16'h0, tm.count_b}, 32'hffff, `RESP_OKAY);
        $display("capture done");
        run <= 1'b1;
        cmp(4'h8, 1'b1, 3'h4);
        repeat (5) @(posedge clk);
        chk(32'(pin), 32'h1);
        rd_reg(`IDX_CTRL, 32'ha8, 32'hbf, `RESP_OKAY);
        wr_reg(`IDX_CTRL, 16'h0080);
        @(posedge clk);
        chk(32'(pin), 32'h0);
        cmp(4'h1, 1'b1, 3'h6);
        repeat (2) @(posedge clk);
        wr_reg(`IDX_VALUE, tm.count_b + 16'h0040);
        wt_flag();
        chk(32'({pin, clr}), 32'h2);
        wr_reg(`IDX_TSEL, 16'h0015);
        cmp(4'hb, 1'b0, 3'h5);
        @(posedge clk);
        chk(32'(pin), 32'h0);
        cmp(4'ha, 1'b0, 3'h4);
        cmp(4'h2, 1'b0, 3'h4);
        cmp(4'h9, 1'b0, 3'h0);
        $display("compare done");
        pwm(1'b1, 1'b0, 16'hfc05, 5);
        pwm(1'b1, 1'b1, 16'h027f, 9);
        pwm(1'b1, 1'b0, 16'h0000, 0);
        pwm(1'b0, 1'b0, 16'h0005, 0);
        $display("pwm done");
        end_of_test();
    end
endmodule
